// file: rtl/fcsadc_regs.vh
// Register offsets, field positions, reset values and timing counts for the
// four-input successive-approximation converter control block.
// Assumes an APB slave with 32-bit data, one register per aligned word.
//
// Overview of operation
// - Each sample resolves to 10 bits by successive approximation, one input routed.
// - Fixed mode: channel field picks exactly one of inputs 0 to 3.
// - Scan mode: channel field sets how many inputs, starting at 0, ascending.
// - Reset clears channel field to 00, selecting input 0.
// - Inputs not used for conversion stay readable as plain port bits.
// - Writing 1 to start bit begins a sequence and sets busy flag.
// - Fixed and scan modes each support single and repeat operation.
// - Fixed repeat converts the selected input again and again.
// - Scan repeat restarts at input 0 after the last input, indefinitely.
// - Four conversion speed settings chosen by the speed field.
// - Reset clears speed field to 0, high speed, 160 states per conversion.
// - Single mode end sets end flag, clears busy, raises interrupt request.
// - Clearing repeat bit ends repeat only after the conversion of the last input in the sequence completes.
// - Each input has its own read-only result, overwritten on each completion.
// - Any read of any result register clears the end flag.
// - Reading an upper result byte clears request flag: of any channel in fixed mode, of a channel in use in scan mode.
// - Low byte holds 2 result LSBs, high byte holds 8 result MSBs.
// - As a 16-bit word the result is left-justified; shift right six.
`ifndef FCSADC_REGS_VH
`define FCSADC_REGS_VH

// Byte offsets (printed offsets not word aligned: index times four)
`define FCSADC_IDX_MODE     8'h60
`define FCSADC_IDX_IRQ      8'h61
`define FCSADC_IDX_PORT     8'h62
`define FCSADC_IDX_R0L      8'h68
`define FCSADC_IDX_R0H      8'h69
`define FCSADC_IDX_R1L      8'h6A
`define FCSADC_IDX_R1H      8'h6B
`define FCSADC_IDX_R2L      8'h64
`define FCSADC_IDX_R2H      8'h65
`define FCSADC_IDX_R3L      8'h66
`define FCSADC_IDX_R3H      8'h67

// Mode register fields
`define FCSADC_CH_LSB       0
`define FCSADC_SCAN_BIT     2
`define FCSADC_REP_BIT      3
`define FCSADC_SPD_LSB      4
`define FCSADC_START_BIT    6
`define FCSADC_BUSY_BIT     7
`define FCSADC_END_BIT      8
// Interrupt register fields
`define FCSADC_IEN_BIT      0
`define FCSADC_IREQ_BIT     1

`define FCSADC_CH_RST       2'b00
`define FCSADC_SPD_RST      2'b00

// States per conversion at high speed; slower settings double each step
`define FCSADC_STATES_FAST  160
`endif

// file: rtl/fcsadc_ctrl.v
// Control and sequencing for a four-input 10-bit successive-approximation
// converter, with APB register access.
// Assumes an external comparator answering on CMP_HIGH the compare of the
// selected input against the ladder code on DAC_CODE; pins are asynchronous.
//
// Register access over APB was chosen for this implementation.
`include "fcsadc_regs.vh"

module fcsadc_ctrl
(
  input  wire        CLOCK,
  input  wire        RESET,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  input  wire        CMP_HIGH,
  input  wire [3:0]  PORT_PINS,
  output reg  [9:0]  DAC_CODE,
  output reg  [1:0]  INPUT_SEL,
  output reg         CMP_ENABLE,
  output reg         DONE_IRQ
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_BIT  = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;
  localparam [11:0] FAST_STATES = `FCSADC_STATES_FAST;

  reg  [2:0]  state_r;
  reg  [1:0]  ch_r;
  reg         scan_r;
  reg         rep_r;
  reg  [1:0]  spd_r;
  reg         busy_r;
  reg         end_r;
  reg         ien_r;
  reg         ireq_r;
  reg  [1:0]  cur_r;
  reg  [3:0]  bit_r;
  reg  [9:0]  sar_r;
  reg  [11:0] tick_r;
  reg  [9:0]  res_r [0:3];
  reg  [1:0]  cmp_sync_r;
  reg  [3:0]  pin_m_r;
  reg  [3:0]  pin_r;

  wire        acc    = PSEL & PENABLE & PREADY;
  wire        wr     = acc & PWRITE;
  wire        rd     = acc & ~PWRITE;
  wire [9:0]  idx    = PADDR[11:2];
  wire        aligned = (PADDR[1:0] == 2'b00) & (idx[9:8] == 2'b00);
  wire        wr_mode = wr & aligned & (idx[7:0] == `FCSADC_IDX_MODE);
  wire        wr_irq  = wr & aligned & (idx[7:0] == `FCSADC_IDX_IRQ);
  wire        start   = wr_mode & PWDATA[`FCSADC_START_BIT];

  // Per-step time at each speed: one conversion spans 160 states times 2^spd,
  // spread over ten bit steps of one clock per state
  wire [11:0] step_len = (FAST_STATES / 12'd10) << spd_r;

  reg         rd_res;
  reg         rd_high;
  reg  [1:0]  rd_ch;
  reg         rd_ok;
  reg  [31:0] rd_data;
  reg         last_ch;
  reg  [1:0]  high_ch;

  // Decode, result formatting and read data
  always @*
  begin
    rd_res  = 1'b0;
    rd_high = 1'b0;
    rd_ch   = 2'd0;
    rd_ok   = aligned;
    rd_data = 32'h0000_0000;
    high_ch = scan_r ? ch_r : 2'd3;
    case (idx[7:0])
      `FCSADC_IDX_MODE:
        rd_data = {23'h00_0000, end_r, busy_r, 1'b0, spd_r, rep_r, scan_r, ch_r};
      `FCSADC_IDX_IRQ:
        rd_data = {30'h0000_0000, ireq_r, ien_r};
      `FCSADC_IDX_PORT:
        rd_data = {28'h000_0000, pin_r};
      `FCSADC_IDX_R0L, `FCSADC_IDX_R1L, `FCSADC_IDX_R2L, `FCSADC_IDX_R3L,
      `FCSADC_IDX_R0H, `FCSADC_IDX_R1H, `FCSADC_IDX_R2H, `FCSADC_IDX_R3H:
      begin
        rd_res = 1'b1;
        case (idx[7:0])
          `FCSADC_IDX_R0L: rd_ch = 2'd0;
          `FCSADC_IDX_R0H: rd_ch = 2'd0;
          `FCSADC_IDX_R1L: rd_ch = 2'd1;
          `FCSADC_IDX_R1H: rd_ch = 2'd1;
          `FCSADC_IDX_R2L: rd_ch = 2'd2;
          `FCSADC_IDX_R2H: rd_ch = 2'd2;
          `FCSADC_IDX_R3L: rd_ch = 2'd3;
          default:         rd_ch = 2'd3;
        endcase
        rd_high = (idx[7:0] == `FCSADC_IDX_R0H) |
                  (idx[7:0] == `FCSADC_IDX_R1H) |
                  (idx[7:0] == `FCSADC_IDX_R2H) |
                  (idx[7:0] == `FCSADC_IDX_R3H);
        // Low byte: two LSBs in bits 7:6; high byte: eight MSBs
        if (rd_high)
          rd_data = {24'h00_0000, res_r[rd_ch][9:2]};
        else
          rd_data = {24'h00_0000, res_r[rd_ch][1:0], 6'b00_0000};
      end
      default:
        rd_ok = 1'b0;
    endcase
    if (!aligned)
      rd_ok = 1'b0;
    // Last input of the sequence: selected input in fixed, field in scan
    last_ch = scan_r ? (cur_r == ch_r) : 1'b1;
  end

  // APB slave: one wait state, unmapped addresses answer with an error
  always @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end
    else
    begin
      PREADY  <= PSEL & PENABLE & ~PREADY;
      PSLVERR <= PSEL & PENABLE & ~PREADY & ~rd_ok;
      if (PSEL & PENABLE & ~PREADY & ~PWRITE)
        PRDATA <= rd_ok ? rd_data : 32'h0000_0000;
    end
  end

  // Pins cross into the clock domain through two flops
  always @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      pin_m_r    <= 4'h0;
      pin_r      <= 4'h0;
      cmp_sync_r <= 2'b00;
    end
    else
    begin
      pin_m_r    <= PORT_PINS;
      pin_r      <= pin_m_r;
      // Only the second stage feeds the sequencer
      cmp_sync_r <= {cmp_sync_r[0], CMP_HIGH};
    end
  end

  // Control registers and sequencer
  always @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      state_r    <= ST_IDLE;
      ch_r       <= `FCSADC_CH_RST;
      scan_r     <= 1'b0;
      rep_r      <= 1'b0;
      spd_r      <= `FCSADC_SPD_RST;
      busy_r     <= 1'b0;
      end_r      <= 1'b0;
      ien_r      <= 1'b0;
      ireq_r     <= 1'b0;
      cur_r      <= 2'd0;
      bit_r      <= 4'd0;
      sar_r      <= 10'h000;
      tick_r     <= 12'h000;
      DAC_CODE   <= 10'h000;
      INPUT_SEL  <= 2'd0;
      CMP_ENABLE <= 1'b0;
      DONE_IRQ   <= 1'b0;
      res_r[0]   <= 10'h000;
      res_r[1]   <= 10'h000;
      res_r[2]   <= 10'h000;
      res_r[3]   <= 10'h000;
    end
    else
    begin
      if (wr_mode)
      begin
        ch_r   <= PWDATA[`FCSADC_CH_LSB+1:`FCSADC_CH_LSB];
        scan_r <= PWDATA[`FCSADC_SCAN_BIT];
        rep_r  <= PWDATA[`FCSADC_REP_BIT];
        spd_r  <= PWDATA[`FCSADC_SPD_LSB+1:`FCSADC_SPD_LSB];
      end
      if (wr_irq)
        ien_r <= PWDATA[`FCSADC_IEN_BIT];
      // Software clears; a completion in the same cycle wins below
      if (rd & rd_res)
        end_r <= 1'b0;
      if (rd & rd_res & rd_high & (rd_ch <= high_ch))
        ireq_r <= 1'b0;

      case (state_r)
        ST_IDLE:
        begin
          CMP_ENABLE <= 1'b0;
          if (start)
          begin
            busy_r    <= 1'b1;
            cur_r     <= PWDATA[`FCSADC_SCAN_BIT] ? 2'd0 :
                         PWDATA[`FCSADC_CH_LSB+1:`FCSADC_CH_LSB];
            INPUT_SEL <= PWDATA[`FCSADC_SCAN_BIT] ? 2'd0 :
                         PWDATA[`FCSADC_CH_LSB+1:`FCSADC_CH_LSB];
            bit_r     <= 4'd9;
            sar_r     <= 10'h200;
            DAC_CODE  <= 10'h200;
            tick_r    <= 12'h000;
            CMP_ENABLE <= 1'b1;
            state_r   <= ST_BIT;
          end
        end
        ST_BIT:
        begin
          if (tick_r + 12'd1 >= step_len)
          begin
            tick_r <= 12'h000;
            // Keep the trial bit when the input is above the ladder code
            if (!cmp_sync_r[1])
              sar_r[bit_r] <= 1'b0;
            if (bit_r == 4'd0)
              state_r <= ST_DONE;
            else
            begin
              sar_r[bit_r - 4'd1] <= 1'b1;
              DAC_CODE <= (cmp_sync_r[1] ? sar_r :
                          (sar_r & ~(10'h001 << bit_r))) |
                          (10'h001 << (bit_r - 4'd1));
              bit_r <= bit_r - 4'd1;
            end
          end
          else
            tick_r <= tick_r + 12'd1;
        end
        ST_DONE:
        begin
          res_r[cur_r] <= sar_r;
          if (last_ch && !rep_r)
          begin
            // Repeat ends only at a conversion boundary
            busy_r     <= 1'b0;
            end_r      <= 1'b1;
            ireq_r     <= 1'b1;
            CMP_ENABLE <= 1'b0;
            state_r    <= ST_IDLE;
          end
          else
          begin
            if (scan_r)
              cur_r <= last_ch ? 2'd0 : cur_r + 2'd1;
            if (scan_r)
              INPUT_SEL <= last_ch ? 2'd0 : cur_r + 2'd1;
            if (last_ch)
              end_r <= 1'b1;
            bit_r    <= 4'd9;
            sar_r    <= 10'h200;
            DAC_CODE <= 10'h200;
            state_r  <= ST_BIT;
          end
        end
        default:
          state_r <= ST_IDLE;
      endcase
      // Interrupt pin follows request gated by enable; repeat never raises the request
      DONE_IRQ <= ireq_r & ien_r;
    end
  end

endmodule

// file: verif/fcsadc_analog_model.sv
// Behavioural comparator and ladder on the far side of the converter.
// Assumes the bench supplies the four input levels as 10-bit codes.
module fcsadc_analog_model
(
  input  wire logic        clk,
  input  wire logic [1:0]  sel,
  input  wire logic [9:0]  code,
  input  wire logic        en,
  input  wire logic [39:0] vin,
  output logic             cmp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tog = 1'b0;
  // Disabled comparator output is noise, never a held value
  always @(posedge clk)
    tog <= ~tog;
  assign cmp = en ? (vin[sel*10 +: 10] >= code) : tog;
endmodule

// file: verif/fcsadc_ctrl_assertions.sv
// Port-level checks on the converter control block.
// Assumes one clock and an asynchronous active-high reset.
module fcsadc_ctrl_chk
(
  input wire logic        CLOCK,
  input wire logic        RESET,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic [1:0]  INPUT_SEL,
  input wire logic        CMP_ENABLE,
  input wire logic        DONE_IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  int unsigned run_r;
  always @(posedge CLOCK or posedge RESET)
    if (RESET)
      run_r <= 0;
    else
      run_r <= CMP_ENABLE ? run_r + 1 : 0;
  wire hi_rd = PREADY && !PWRITE && PADDR[2] && (PADDR[8:4] == 5'h19
               || PADDR[8:4] == 5'h1A);
  sequence s_ans; !PREADY ##1 PREADY; endsequence
  property p_ans; $rose(PENABLE) && PSEL |-> s_ans; endproperty
  property p_pulse; PREADY |=> !PREADY; endproperty
  property p_qual; PREADY |-> PSEL && PENABLE; endproperty
  property p_err; PSLVERR |-> PREADY && (PWRITE || PRDATA == 0); endproperty
  property p_rst; $past(RESET) |-> INPUT_SEL == 2'b00 && !CMP_ENABLE;
  endproperty
  property p_len; $fell(CMP_ENABLE) |-> run_r >= 160; endproperty
  property p_irq; $rose(DONE_IRQ) |-> !CMP_ENABLE; endproperty
  property p_clr; hi_rd && DONE_IRQ |-> ##[1:3] !DONE_IRQ; endproperty
  a_ans: assert property (p_ans) else $error("ready late");
  a_pulse: assert property (p_pulse) else $error("ready held");
  a_qual: assert property (p_qual) else $error("stray ready");
  a_err: assert property (p_err) else $error("bad error reply");
  a_rst: assert property (p_rst) else $error("bad reset state");
  a_len: assert property (p_len) else $error("short conversion");
  a_irq: assert property (p_irq) else $error("early request");
  a_clr: assert property (p_clr) else $error("request kept");
endmodule
bind fcsadc_ctrl fcsadc_ctrl_chk i_fcsadc_ctrl_chk (.CLOCK(CLOCK),
  .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .INPUT_SEL(INPUT_SEL), .CMP_ENABLE(CMP_ENABLE), .DONE_IRQ(DONE_IRQ));

// file: verif/fcsadc_ctrl_tb.sv
// Self-checking bench for the converter control block over APB.
// Assumes the analog model on the far side and a 40 MHz clock.
module fcsadc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic pready, pslverr, er, cmp, cmp_en, irq;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0]  pins = 0;
  logic [9:0]  dac;
  logic [1:0]  isel;
  logic [39:0] vin = 0;
  logic [15:0] rs = 16'h004D;
  int n_mismatch = 0, n_tests = 0, tc;
  always #12.5 clock = ~clock;
  fcsadc_ctrl i_fcsadc_ctrl (.CLOCK(clock), .RESET(reset), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CMP_HIGH(cmp),
    .PORT_PINS(pins), .DAC_CODE(dac), .INPUT_SEL(isel),
    .CMP_ENABLE(cmp_en), .DONE_IRQ(irq));
  fcsadc_analog_model i_fcsadc_analog_model (.clk(clock), .sel(isel),
    .code(dac), .en(cmp_en), .vin(vin), .cmp(cmp));
  function automatic [15:0] lfsr(input [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic [11:0] hi_adr(input [1:0] c);
    return (c[1] ? 12'h0194 : 12'h01A4) + {c[0], 3'h0};
  endfunction
  task automatic chk(input [31:0] got, input [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input w, input [11:0] a, input [31:0] d);
    int k;
    @(posedge clock);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1;
    k = 0;
    do
    begin
      @(posedge clock);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (k >= 50)
      n_mismatch++;
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wait_irq(input int lim);
    int k;
    k = 0;
    while (irq !== 1'b1 && k < lim)
    begin
      @(posedge clock);
      k++;
    end
    chk(irq, 1);
  endtask
  task automatic finish_test;
    $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #(25ns * 20000);
    n_mismatch++;
    finish_test;
  end
  initial
  begin
    repeat (10) @(posedge clock);
    reset <= 0;
    apb(0, 12'h0180, 0); chk(rd, 0);
    apb(0, 12'h01FC, 0); chk({rd[30:0], er}, 1);
    pins <= rs[3:0];
    apb(0, 12'h0188, 0); chk(rd, {28'h000_0000, pins});
    apb(1, 12'h0184, 1);
    // Speed follows the channel so every setting is exercised
    for (int c = 0; c < 4; c++)
    begin
      rs = lfsr(rs);
      vin[c*10 +: 10] <= rs[9:0];
      apb(1, 12'h0180, 32'h0000_0040 | (c << 4) | c);
      apb(0, 12'h0180, 0); chk(rd[7], 1);
      wait_irq(400 << c);
      apb(0, 12'h0180, 0); chk(rd[8:7], 2'b10);
      apb(0, hi_adr(c) - 4, 0); chk(rd, {vin[c*10 +: 2], 6'h00});
      apb(0, 12'h0180, 0); chk(rd[8], 0);
      apb(0, hi_adr(c), 0); chk(rd, vin[c*10+2 +: 8]);
      repeat (3) @(posedge clock);
      chk(irq, 0);
    end
    rs = lfsr(rs);
    vin <= {rs[9:0], rs[15:6], rs[12:3], rs[15:6] ^ rs[9:0]};
    apb(1, 12'h0180, 32'h0000_0046);
    wait_irq(700);
    for (int c = 0; c < 3; c++)
    begin
      apb(0, hi_adr(c), 0); chk(rd, vin[c*10+2 +: 8]);
    end
    apb(1, 12'h0184, 0);
    for (int m = 0; m < 2; m++)
    begin
      tc = m ? 0 : 3;
      apb(1, 12'h0180, m ? 32'h0000_004D : 32'h0000_004B);
      repeat (400) @(posedge clock);
      rs = lfsr(rs);
      vin[tc*10 +: 10] <= rs[9:0];
      repeat (500) @(posedge clock);
      apb(0, hi_adr(tc), 0); chk(rd, vin[tc*10+2 +: 8]);
      apb(1, 12'h0180, m ? 32'h0000_0005 : 32'h0000_0003);
      // A scan finishes its sequence: allow two conversions
      repeat (400) @(posedge clock);
      apb(0, 12'h0180, 0); chk(rd[7], 0);
    end
    finish_test;
  end
endmodule
